// File: mcpg_misc_config.sv
// Miscellaneous configuration register bank with clock-RAM locks, USB forcing,
// legacy decode enables, three small pin groups and a power gating timer.
// Assumes configuration cycles arrive on mclk; pins and voltage comparators are
// asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module mcpg_misc_config
  import mcpg_pkg::*;
#(
  parameter int UNIT_CYCLES = MCPG_IDLE_UNIT_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Configuration cycles.
  input wire mcpg_cfg_req_t cfgReq,
  output logic [31:0] cfgRdData,
  output logic cfgRdValid,
  // Clock-RAM access check.
  input wire logic ramAccess,
  input wire logic [7:0] ramIndex,
  output logic ramBlocked,
  // USB forcing.
  output logic [4:0] usbHostReset,
  output logic usbPhyPowerDown,
  output logic usbPllPowerDown,
  output logic usbPhyReset,
  // DMA, bridge and interrupt controller.
  output logic dmaExtraIdle,
  output logic bridgeSoftResetAllow,
  output logic intrCtrlMemMapped,
  output logic [26:0] intrCtrlBase,
  // Legacy I/O decode.
  input wire logic ioAccess,
  input wire logic [15:0] ioAddr,
  output logic ioClaim,
  // Pin groups A, B, C.
  input wire logic [11:0] pinIn,
  output logic [11:0] pinOut,
  output logic [11:0] pinOe,
  output logic [3:0] groupCGpioMode,
  input wire logic bootOnPciBus,
  // System bus base held at offset 10h.
  input wire logic [27:0] systemBusBaseField,
  // Power gating.
  input wire logic [6:0] unitIdle,
  input wire logic cpuInC3,
  input wire logic [7:0] voltageInReached,
  output logic generalPinFiveOut,
  output logic generalPinFiveOe
);

  // Clock-RAM lock state and the other register fields.
  logic [4:0] lockRam;
  logic lockWritten;
  logic [7:0] usbForce;
  logic [15:0] testReg;
  logic [31:0] intrCfg;
  logic [31:0] decodeEn;
  logic [3:0] outA, outB, outC;
  logic [3:0] oeNA, oeNB, oeNC;
  logic [3:0] funcC;
  logic [7:0] unitChecks;
  logic [7:0] voltChecks;
  logic [7:0] idleTime;
  // Synchroniser stages for pins and voltage comparators.
  logic [19:0] syncS1, syncS2, syncS3, syncStable;
  logic [11:0] pinLevel;
  logic [7:0] voltLevel;
  // Power gating timer, write decode and read word.
  mcpg_gate_state_t gateState;
  logic [15:0] prescale;
  logic [6:0] unitCount;
  logic condsMet;
  logic [5:0] dw;
  logic wrHit;
  logic [31:0] rdWord;

  assign dw = cfgReq.addr[7:2];
  assign wrHit = cfgReq.wr;

  // Apply one byte lane of a write when its enable is set.
  // Lanes without an enable keep their old byte, so partial writes leave neighbours alone.
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                      input logic en);
    lane = en ? nw : old;
  endfunction

  // Lock bits take a single write after reset; the first write seals them.
  // All five bits seal together: software must set every wanted lock in that one write.
  // Even a first write of zero seals, so later code can never alter the protection.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lockRam <= 5'h00;
      lockWritten <= 1'b0;
    end else if (wrHit && dw == MCPG_OFS_CLOCK_RAM_LOCK[7:2] && cfgReq.be[2] && !lockWritten) begin
      lockRam <= cfgReq.wdata[20:16];
      lockWritten <= 1'b1;
    end
  end

  // Clock-RAM access is refused when its range is locked.
  // The flag is registered, so the RAM port sees it one cycle after the access.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ramBlocked <= 1'b0;
    end else begin
      ramBlocked <= ramAccess && (
        (lockRam[0] && ramIndex >= 8'h38 && ramIndex <= 8'h3f) ||
        (lockRam[1] && ramIndex >= 8'hf0) ||
        (lockRam[2] && ramIndex[7:4] == 4'he) ||
        (lockRam[3] && ramIndex[7:4] == 4'hd) ||
        (lockRam[4] && ramIndex[7:4] == 4'hc));
    end
  end

  // USB forcing and test register share the dwords at 68h and 6Ch.
  // Lanes 0 and 1 of dword 68h are outside this bank and ignored; lane 2 holds the locks, written in the lock block.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      usbForce <= 8'h00;
      testReg <= 16'h0000;
    end else if (wrHit) begin
      if (dw == MCPG_OFS_USB_FORCE_RESET[7:2]) begin
        usbForce <= lane(usbForce, cfgReq.wdata[31:24], cfgReq.be[3]);
      end
      if (dw == MCPG_OFS_TEST_DMA_TIMING[7:2]) begin
        // Test-only bits are stored as written; software leaves them alone.
        testReg[7:0] <= lane(testReg[7:0], cfgReq.wdata[7:0], cfgReq.be[0]);
        testReg[15:8] <= lane(testReg[15:8], cfgReq.wdata[15:8], cfgReq.be[1]);
      end
    end
  end

  // Interrupt controller base and legacy decode enables, reserved bits masked.
  // Masked bits always read zero, so a careless write cannot set a reserved field.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      intrCfg <= MCPG_RST_INTR_CTRL_BASE;
      decodeEn <= MCPG_RST_LEGACY_DECODE;
    end else if (wrHit) begin
      for (int b = 0; b < 4; b++) begin
        if (cfgReq.be[b] && dw == MCPG_OFS_INTR_CTRL_BASE[7:2]) begin
          intrCfg[b*8 +: 8] <= cfgReq.wdata[b*8 +: 8] & MCPG_MASK_INTR_CTRL_BASE[b*8 +: 8];
        end
        if (cfgReq.be[b] && dw == MCPG_OFS_LEGACY_DECODE[7:2]) begin
          decodeEn[b*8 +: 8] <= cfgReq.wdata[b*8 +: 8] & MCPG_MASK_LEGACY_DECODE[b*8 +: 8];
        end
      end
    end
  end

  // Pin group registers; group A at 7Eh, groups B and C at 80h and 82h.
  // Status nibbles sit in the byte above each output byte and are read only; their write data is dropped.
  // Groups A and B have no function enables, so their pins drive on the output enable alone, except the boot chip select in group B.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      outA <= 4'h0;
      outB <= 4'h0;
      outC <= 4'h0;
      oeNA <= MCPG_RST_PIN_OE_N;
      oeNB <= MCPG_RST_PIN_OE_N;
      oeNC <= MCPG_RST_PIN_OE_N;
      funcC <= 4'h0;
    end else if (wrHit) begin
      if (dw == MCPG_OFS_PIN_GROUP_A[7:2] && cfgReq.be[2]) begin
        {oeNA, outA} <= cfgReq.wdata[23:16];
      end
      if (dw == MCPG_OFS_PIN_GROUP_B[7:2]) begin
        if (cfgReq.be[0]) begin
          {oeNB, outB} <= cfgReq.wdata[7:0];
        end
        if (cfgReq.be[2]) begin
          {oeNC, outC} <= cfgReq.wdata[23:16];
        end
        if (cfgReq.be[3]) begin
          funcC <= cfgReq.wdata[31:28];
        end
      end
    end
  end

  // Power gating control registers.
  // Each lane updates alone, so the idle time can change without touching the checks.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unitChecks <= 8'h00;
      voltChecks <= 8'h00;
      idleTime <= 8'h00;
    end else if (wrHit && dw == MCPG_OFS_GATE_UNIT_CHECKS[7:2]) begin
      unitChecks <= lane(unitChecks, cfgReq.wdata[7:0], cfgReq.be[0]);
      voltChecks <= lane(voltChecks, cfgReq.wdata[15:8], cfgReq.be[1]);
      idleTime <= lane(idleTime, cfgReq.wdata[23:16], cfgReq.be[2]);
    end
  end

  // Three-stage synchroniser; a change counts once stages two and three agree.
  // The agree stage costs a cycle of latency but filters a pulse of one cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncS1 <= 20'h00000;
      syncS2 <= 20'h00000;
      syncS3 <= 20'h00000;
      syncStable <= 20'h00000;
    end else begin
      syncS1 <= {voltageInReached, pinIn};
      syncS2 <= syncS1;
      syncS3 <= syncS2;
      syncStable <= (~(syncS2 ^ syncS3) & syncS3) | ((syncS2 ^ syncS3) & syncStable);
    end
  end

  assign pinLevel = syncStable[11:0];
  assign voltLevel = syncStable[19:12];

  // Read word for the addressed dword; unmapped dwords read zero.
  // Reads have no side effects, so software may read any dword as often as it likes.
  always_comb begin
    rdWord = 32'h0000_0000;
    unique case (dw)
      MCPG_OFS_CLOCK_RAM_LOCK[7:2]: rdWord = {usbForce, {3'h0, lockRam}, 16'h0000};
      MCPG_OFS_TEST_DMA_TIMING[7:2]: rdWord = {16'h0000, testReg};
      MCPG_OFS_INTR_CTRL_BASE[7:2]: rdWord = intrCfg;
      MCPG_OFS_LEGACY_DECODE[7:2]: rdWord = decodeEn;
      MCPG_OFS_PIN_GROUP_A[7:2]: rdWord = {4'h0, pinLevel[3:0], oeNA, outA, 16'h0000};
      MCPG_OFS_PIN_GROUP_B[7:2]:
        rdWord = {funcC, pinLevel[11:8], oeNC, outC, 4'h0, pinLevel[7:4], oeNB, outB};
      MCPG_OFS_SYS_BUS_BASE[7:2]: rdWord = {systemBusBaseField, 4'h1};
      MCPG_OFS_GATE_UNIT_CHECKS[7:2]: rdWord = {8'h00, idleTime, voltChecks, unitChecks};
      default: rdWord = 32'h0000_0000;
    endcase
  end

  // Read data appears one cycle after the request and holds until the next read.
  // A read and a write to one dword in the same cycle return the old value.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfgRdData <= 32'h0000_0000;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgReq.rd;
      if (cfgReq.rd) begin
        cfgRdData <= rdWord;
      end
    end
  end

  // Control outputs follow their register bits one cycle later, two cycles after the write.
  // The extra stage keeps every output straight from a flip-flop at the cost of a cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      usbHostReset <= 5'h00;
      usbPhyPowerDown <= 1'b0;
      usbPllPowerDown <= 1'b0;
      usbPhyReset <= 1'b0;
      dmaExtraIdle <= 1'b0;
      bridgeSoftResetAllow <= 1'b0;
      intrCtrlMemMapped <= MCPG_RST_INTR_CTRL_BASE[MCPG_INTR_MEM_MAP_BIT];
      intrCtrlBase <= MCPG_RST_INTR_CTRL_BASE[31:5];
    end else begin
      usbHostReset <= usbForce[4:0];
      usbPhyPowerDown <= usbForce[5];
      usbPllPowerDown <= usbForce[6];
      usbPhyReset <= usbForce[7];
      dmaExtraIdle <= testReg[MCPG_TEST_DMA_TIMING_BIT];
      bridgeSoftResetAllow <= testReg[MCPG_TEST_BRIDGE_RESET_BIT];
      intrCtrlMemMapped <= intrCfg[MCPG_INTR_MEM_MAP_BIT];
      intrCtrlBase <= intrCfg[31:5];
    end
  end

  // Legacy port claim; each range is gated by its own enable bit.
  // Reserved enable bits 10, 12, 13 and 15 upward claim nothing.
  // The claim is registered and so answers one cycle after the access.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ioClaim <= 1'b0;
    end else begin
      ioClaim <= ioAccess && (
        (decodeEn[0] && (ioAddr <= 16'h001f || (ioAddr >= 16'h0080 && ioAddr <= 16'h008f) ||
          (ioAddr >= 16'h00c0 && ioAddr <= 16'h00df) || ioAddr == 16'h040b ||
          ioAddr == 16'h04d6)) ||
        (decodeEn[1] && ioAddr >= 16'h0040 && ioAddr <= 16'h0043) ||
        (decodeEn[2] && ioAddr == 16'h0070) ||
        (decodeEn[3] && ioAddr == 16'h0071) ||
        (decodeEn[4] && ioAddr == 16'h0c14) ||
        (decodeEn[5] && (ioAddr == 16'h0c49 || ioAddr == 16'h0c4a)) ||
        (decodeEn[6] && ioAddr == 16'h0c52) ||
        (decodeEn[7] && ioAddr == 16'h0c6c) ||
        (decodeEn[8] && ioAddr == 16'h0c6f) ||
        (decodeEn[9] && (ioAddr == 16'h0cd6 || ioAddr == 16'h0cd7)) ||
        (decodeEn[11] && (ioAddr == 16'h0c50 || ioAddr == 16'h0c51)) ||
        (decodeEn[14] && ioAddr == 16'h0092));
    end
  end

  // Pin drivers; the enable is active low in the register, high on the port.
  // Output data passes even while a pin floats, so enabling it shows the last level at once.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pinOut <= 12'h000;
      pinOe <= 12'h000;
      groupCGpioMode <= 4'h0;
    end else begin
      pinOut <= {outC, outB, outA};
      pinOe[3:0] <= ~oeNA;
      pinOe[7:4] <= ~oeNB;
      // The boot chip select stays with the boot bus while PCI carries boot memory.
      pinOe[4 + MCPG_BOOT_CS_PIN] <= ~oeNB[MCPG_BOOT_CS_PIN] && !bootOnPciBus;
      pinOe[11:8] <= ~oeNC & funcC;
      groupCGpioMode <= funcC;
    end
  end

  // All selected conditions together; unselected ones are ignored.
  // Voltage inputs are used after synchronising; units and the sleep state share this clock.
  assign condsMet = idleTime[MCPG_GATE_ENABLE_BIT] &&
    ((unitChecks[6:0] & ~unitIdle) == 7'h00) &&
    (!unitChecks[MCPG_GATE_C3_BIT] || cpuInC3) &&
    ((voltChecks & ~voltLevel) == 8'h00);

  // Idle timer; losing any condition restarts it and drops the output.
  // The prescaler only runs while waiting, so partial units never carry over.
  // The longest idle time, 127 units, is about a quarter of a millisecond at 2 us a unit.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gateState <= MCPG_GATE_OFF;
      prescale <= 16'h0000;
      unitCount <= 7'h00;
    end else if (!condsMet) begin
      gateState <= MCPG_GATE_OFF;
      prescale <= 16'h0000;
      unitCount <= 7'h00;
    end else begin
      unique case (gateState)
        MCPG_GATE_OFF: begin
          gateState <= MCPG_GATE_WAIT;
        end
        MCPG_GATE_WAIT: begin
          // The compare comes before the count moves, so an idle time of zero skips the wait.
          if (unitCount >= idleTime[6:0]) begin
            gateState <= MCPG_GATE_ON;
          end else if (prescale == 16'(UNIT_CYCLES - 1)) begin
            prescale <= 16'h0000;
            unitCount <= unitCount + 7'h01;
          end else begin
            prescale <= prescale + 16'h0001;
          end
        end
        MCPG_GATE_ON: begin
          gateState <= MCPG_GATE_ON;
        end
        default: begin
          gateState <= MCPG_GATE_OFF;
        end
      endcase
    end
  end

  // Voltage control goes out on general pin five while the function is enabled.
  // The enable follows the function bit alone, so the pin is driven low while waiting.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      generalPinFiveOut <= 1'b0;
      generalPinFiveOe <= 1'b0;
    end else begin
      generalPinFiveOut <= condsMet && gateState == MCPG_GATE_ON;
      generalPinFiveOe <= idleTime[MCPG_GATE_ENABLE_BIT];
    end
  end

endmodule

`default_nettype wire

// File: mcpg_pkg.sv
// Constants, field layouts and carrier types for the miscellaneous configuration
// and power gating register bank.
// Assumes a configuration-cycle port with dword addresses and byte enables, on mclk.
// What this block does
// - Each clock-RAM lock bit takes one write only; later writes change nothing.
// - USB reset bits 4:0 hold each USB host controller in reset while set.
// - Bit 5 powers down the PHY, bit 6 its PLL, bit 7 resets the PHY.
// - DMA timing bit makes legacy DMA insert one idle clock between requests.
// - Test register bit 5 makes the bridge soft-reset enable bit writable.
// - Interrupt controller bit 3 selects memory decode at 1, I/O at 0; resets 1.
// - Bits 31:5 give the interrupt controller decode base address.
// - Each set decode-enable bit claims its legacy ports; cleared bits do not.
// - Decode bit 0 gates the DMA port ranges and resets to one.
// - Pin output bit drives the pin level only while enables permit driving.
// - Output enables are active low, tristate at one, reset to all ones.
// - The status field returns the sampled input level of each pin.
// - In group C a pin is general purpose only when its enable bit is one.
// - Boot chip-select output enable acts only when PCI is not the boot bus.
// - System bus base is read only, mirrors offset 10h, bit 0 reads one.
// - Selected units must all be idle before the voltage control output asserts.
// - With bit 7 set the output asserts only while the CPU sleeps in C3.
// - Each selected voltage input must reach its threshold before assertion.
// - Assertion follows conditions holding for the idle time in 2 us units.
// - Idle-time register bit 7 enables the power gating function.
// - The voltage control output drives general pin five.
package mcpg_pkg;

  // Byte offsets in configuration space.
  localparam logic [7:0] MCPG_OFS_CLOCK_RAM_LOCK = 8'h6a;
  localparam logic [7:0] MCPG_OFS_USB_FORCE_RESET = 8'h6b;
  localparam logic [7:0] MCPG_OFS_TEST_DMA_TIMING = 8'h6c;
  localparam logic [7:0] MCPG_OFS_INTR_CTRL_BASE = 8'h74;
  localparam logic [7:0] MCPG_OFS_LEGACY_DECODE = 8'h78;
  localparam logic [7:0] MCPG_OFS_PIN_GROUP_A = 8'h7e;
  localparam logic [7:0] MCPG_OFS_PIN_GROUP_B = 8'h80;
  localparam logic [7:0] MCPG_OFS_PIN_GROUP_C = 8'h82;
  localparam logic [7:0] MCPG_OFS_SYS_BUS_BASE = 8'h90;
  localparam logic [7:0] MCPG_OFS_GATE_UNIT_CHECKS = 8'h98;
  localparam logic [7:0] MCPG_OFS_GATE_VOLT_CHECKS = 8'h99;
  localparam logic [7:0] MCPG_OFS_GATE_IDLE_TIME = 8'h9a;

  // Values after reset and write masks.
  localparam logic [31:0] MCPG_RST_INTR_CTRL_BASE = 32'hfec0_0008;
  localparam logic [31:0] MCPG_RST_LEGACY_DECODE = 32'h0000_4bff;
  localparam logic [31:0] MCPG_MASK_LEGACY_DECODE = 32'h0000_4bff;
  localparam logic [31:0] MCPG_MASK_INTR_CTRL_BASE = 32'hffff_ffe8;
  localparam logic [3:0] MCPG_RST_PIN_OE_N = 4'hf;

  // Field positions.
  localparam int MCPG_TEST_DMA_TIMING_BIT = 0;
  localparam int MCPG_TEST_BRIDGE_RESET_BIT = 5;
  localparam int MCPG_INTR_MEM_MAP_BIT = 3;
  localparam int MCPG_GATE_C3_BIT = 7;
  localparam int MCPG_GATE_ENABLE_BIT = 7;
  localparam int MCPG_BOOT_CS_PIN = 1;

  // Idle time unit and the clock that counts it.
  localparam int MCPG_CLOCK_NS = 50;
  localparam int MCPG_IDLE_UNIT_NS = 2000;
  localparam int MCPG_IDLE_UNIT_CYCLES = MCPG_IDLE_UNIT_NS / MCPG_CLOCK_NS;

  // One configuration cycle as seen by this function.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } mcpg_cfg_req_t;

  // Power gating sequence.
  typedef enum logic [2:0] {
    MCPG_GATE_OFF = 3'b001,
    MCPG_GATE_WAIT = 3'b010,
    MCPG_GATE_ON = 3'b100
  } mcpg_gate_state_t;

endpackage

// File: mcpg_misc_config_checker.sv
// Concurrent checks for the configuration and power gating bank.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mcpg_misc_config_checker
  import mcpg_pkg::*;
#(
  parameter int UNIT_CYCLES = MCPG_IDLE_UNIT_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Configuration side.
  input wire mcpg_cfg_req_t cfgReq,
  input wire logic [31:0] cfgRdData,
  input wire logic cfgRdValid,
  input wire logic [27:0] systemBusBaseField,
  // Control outputs.
  input wire logic [4:0] usbHostReset,
  input wire logic usbPhyPowerDown,
  input wire logic dmaExtraIdle,
  input wire logic bridgeSoftResetAllow,
  input wire logic intrCtrlMemMapped,
  input wire logic [26:0] intrCtrlBase,
  // Decode and pins.
  input wire logic ramAccess,
  input wire logic [7:0] ramIndex,
  input wire logic ramBlocked,
  input wire logic ioAccess,
  input wire logic ioClaim,
  input wire logic [11:0] pinOe,
  input wire logic bootOnPciBus,
  input wire logic generalPinFiveOut,
  input wire logic generalPinFiveOe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Write data two edges back, so stored fields can be compared after their latency.
  logic [31:0] wd1;
  logic [31:0] wd2;
  always_ff @(posedge mclk) begin
    wd1 <= cfgReq.wdata;
    wd2 <= wd1;
  end

  // Decoded writes of whole fields and the system bus base read.
  wire usbWr = cfgReq.wr && cfgReq.addr[7:2] == 6'h1a && cfgReq.be[3];
  wire tmWr = cfgReq.wr && cfgReq.addr[7:2] == 6'h1b && cfgReq.be[0];
  wire icWr = cfgReq.wr && cfgReq.addr[7:2] == 6'h1d && cfgReq.be == 4'hf;
  wire sbRd = cfgReq.rd && cfgReq.addr[7:2] == 6'h24;

  chk_base_mirror_read: assert property (sbRd |=> cfgRdValid &&
    cfgRdData == {$past(systemBusBaseField), 4'h1})
    else $error("system bus base mirror read wrong");
  chk_usb_force_copy: assert property (usbWr |-> ##2
    {usbPhyPowerDown, usbHostReset} == wd2[29:24])
    else $error("usb force outputs do not follow write");
  chk_timing_bits_copy: assert property (tmWr |-> ##2
    dmaExtraIdle == wd2[0] && bridgeSoftResetAllow == wd2[5])
    else $error("dma timing or bridge allow wrong");
  chk_intr_base_copy: assert property (icWr |-> ##2
    intrCtrlBase == wd2[31:5] && intrCtrlMemMapped == wd2[3])
    else $error("interrupt controller base wrong");
  chk_ram_open_range: assert property (!ramAccess || ramIndex < 8'h38 |=> !ramBlocked)
    else $error("ram blocked outside locked ranges");
  chk_io_idle_quiet: assert property (!ioAccess |=> !ioClaim)
    else $error("io claim without access");
  chk_boot_cs_hold: assert property (bootOnPciBus [*2] |-> !pinOe[5])
    else $error("boot chip select driven while boot on pci");
  chk_gate_needs_enable: assert property ($rose(generalPinFiveOut) |-> generalPinFiveOe)
    else $error("voltage control rose while disabled");
  chk_gate_drop_fast: assert property ($fell(generalPinFiveOe) |-> ##[0:2] !generalPinFiveOut)
    else $error("voltage control held after disable");

  // Main scenarios reached.
  cov_usb_write: cover property (usbWr);
  cov_ram_blocked: cover property (ramBlocked);
  cov_gate_rise: cover property ($rose(generalPinFiveOut));
endmodule

bind mcpg_misc_config mcpg_misc_config_checker #(.UNIT_CYCLES(UNIT_CYCLES)) chk_u (
  .mclk(mclk), .sys_rst(sys_rst), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
  .cfgRdValid(cfgRdValid), .systemBusBaseField(systemBusBaseField),
  .usbHostReset(usbHostReset), .usbPhyPowerDown(usbPhyPowerDown),
  .dmaExtraIdle(dmaExtraIdle), .bridgeSoftResetAllow(bridgeSoftResetAllow),
  .intrCtrlMemMapped(intrCtrlMemMapped), .intrCtrlBase(intrCtrlBase),
  .ramAccess(ramAccess), .ramIndex(ramIndex), .ramBlocked(ramBlocked),
  .ioAccess(ioAccess), .ioClaim(ioClaim), .pinOe(pinOe), .bootOnPciBus(bootOnPciBus),
  .generalPinFiveOut(generalPinFiveOut), .generalPinFiveOe(generalPinFiveOe)
);
`default_nettype wire

// File: mcpg_misc_config_tb.sv
// Self-checking bench for the configuration and power gating bank.
// Assumes the package, design and bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module mcpg_misc_config_tb;
  import mcpg_pkg::*;
  logic mclk, sys_rst, ramAccess, ioAccess, bootOnPciBus, cpuInC3, cfgRdValid, ramBlocked;
  logic usbPhyPowerDown, usbPllPowerDown, usbPhyReset, dmaExtraIdle, bridgeSoftResetAllow;
  logic intrCtrlMemMapped, ioClaim, generalPinFiveOut, generalPinFiveOe;
  logic [31:0] cfgRdData, rd;
  logic [26:0] intrCtrlBase;
  logic [27:0] systemBusBaseField;
  logic [15:0] ioAddr;
  logic [11:0] pinIn, pinOut, pinOe;
  logic [7:0] ramIndex, voltageInReached;
  logic [6:0] unitIdle;
  logic [4:0] usbHostReset;
  logic [3:0] groupCGpioMode;
  mcpg_cfg_req_t cfgReq;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // Index and expected block flag, bit 8, after ranges 1..4 are sealed.
  logic [8:0] lockTab [7] = '{9'h1ff, 9'h1e0, 9'h1df, 9'h1c0, 9'h038, 9'h037, 9'h0bf};

  // Short unit time keeps the idle waits brief.
  mcpg_misc_config #(.UNIT_CYCLES(4)) dut_u (.mclk, .sys_rst, .cfgReq, .cfgRdData,
    .cfgRdValid, .ramAccess, .ramIndex, .ramBlocked, .usbHostReset, .usbPhyPowerDown,
    .usbPllPowerDown, .usbPhyReset, .dmaExtraIdle, .bridgeSoftResetAllow,
    .intrCtrlMemMapped, .intrCtrlBase, .ioAccess, .ioAddr, .ioClaim, .pinIn, .pinOut,
    .pinOe, .groupCGpioMode, .bootOnPciBus, .systemBusBaseField, .unitIdle, .cpuInC3,
    .voltageInReached, .generalPinFiveOut, .generalPinFiveOe);

  // Clock of 50 ns period.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Hang guard: the tests need well under a thousand cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Each access starts one edge later, so a strobe never changes twice in one step.
  task automatic cfgWrite(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    tick(1);
    cfgReq = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
    tick(1);
    cfgReq.wr = 1'b0;
  endtask

  task automatic cfgRead(input logic [7:0] a);
    tick(1);
    cfgReq.rd = 1'b1;
    cfgReq.addr = a;
    tick(1);
    cfgReq.rd = 1'b0;
    check({31'h0, cfgRdValid}, 32'h1);
    rd = cfgRdData;
  endtask

  // One clock-RAM or legacy I/O access; the flag answers one cycle later.
  task automatic probe(input bit io, input logic [15:0] a, input logic exp);
    tick(1);
    ioAccess = io;
    ramAccess = !io;
    ioAddr = a;
    ramIndex = a[7:0];
    tick(1);
    ioAccess = 1'b0;
    ramAccess = 1'b0;
    check({31'h0, io ? ioClaim : ramBlocked}, {31'h0, exp});
  endtask

  task automatic doReset;
    sys_rst = 1'b1;
    tick(6);
    sys_rst = 1'b0;
  endtask

  // The voltage control must rise no sooner than lo cycles and before hi cycles.
  task automatic gateWait(input int lo, input int hi);
    int n;
    n = 0;
    while (generalPinFiveOut !== 1'b1 && n < hi) begin
      tick(1);
      n++;
    end
    check({31'h0, n >= lo && n < hi}, 32'h1);
  endtask

  initial begin
    cfgReq = '0;
    {ramAccess, ioAccess, cpuInC3, ramIndex, ioAddr, voltageInReached} = '0;
    bootOnPciBus = 1'b1;
    pinIn = 12'ha5c;
    systemBusBaseField = 28'h1234567;
    unitIdle = 7'h7f;
    doReset();
    cfgRead(8'h74);
    check(rd, 32'hfec0_0008);
    cfgRead(8'h78);
    check(rd, 32'h0000_4bff);
    cfgRead(8'h80);
    check(rd & 32'hf0ff_00ff, 32'h00f0_00f0);
    check({20'h0, pinOe}, 32'h0);
    probe(1, 16'h0010, 1'b1);
    probe(1, 16'h0085, 1'b1);
    probe(1, 16'h0300, 1'b0);
    cfgWrite(8'h78, 4'hf, 32'h0000_4bfe);
    probe(1, 16'h0010, 1'b0);
    probe(1, 16'h0070, 1'b1);
    // A second lock write must be refused.
    probe(0, 16'h0038, 1'b0);
    cfgWrite(8'h68, 4'h4, 32'h0001_0000);
    cfgWrite(8'h68, 4'h4, 32'h001f_0000);
    cfgRead(8'h68);
    check(rd & 32'h00ff_0000, 32'h0001_0000);
    probe(0, 16'h003f, 1'b1);
    probe(0, 16'h00f0, 1'b0);
    doReset();
    cfgRead(8'h68);
    check(rd, 32'h0);
    cfgWrite(8'h68, 4'h4, 32'h001e_0000);
    for (int i = 0; i < 7; i++) probe(0, {8'h0, lockTab[i][7:0]}, lockTab[i][8]);
    for (int i = 0; i < 2; i++) begin
      cfgWrite(8'h68, 4'h8, i ? 32'h5a00_0000 : 32'ha500_0000);
      tick(2);
      check({usbPhyReset, usbPllPowerDown, usbPhyPowerDown, usbHostReset},
        i ? 8'h5a : 8'ha5);
    end
    // Only lane 0 is written, with its test-only bits left at zero.
    cfgWrite(8'h6c, 4'h1, 32'h0000_0021);
    tick(2);
    check({dmaExtraIdle, bridgeSoftResetAllow}, 2'h3);
    cfgWrite(8'h74, 4'hf, 32'h1234_5677);
    tick(2);
    check({intrCtrlMemMapped, intrCtrlBase}, {1'b0, 27'h091a2b3});
    cfgRead(8'h74);
    check(rd, 32'h1234_5660);
    cfgWrite(8'h7c, 4'hc, 32'h0005_0000);
    cfgWrite(8'h80, 4'hf, 32'h0006_000a);
    tick(2);
    check({20'h0, pinOe}, 32'h0df);
    check({20'h0, pinOut & pinOe}, 32'h085);
    bootOnPciBus = 1'b0;
    cfgWrite(8'h80, 4'hc, 32'hf006_0000);
    tick(2);
    check({16'h0, groupCGpioMode, pinOe}, 32'hffff);
    check({20'h0, pinOut}, 32'h6a5);
    cfgRead(8'h7c);
    check({24'h0, rd[27:24]}, {28'h0, pinIn[3:0]});
    cfgRead(8'h80);
    check({24'h0, rd[27:24], rd[11:8]}, {24'h0, pinIn[11:4]});
    cfgWrite(8'h90, 4'hf, 32'h0);
    cfgRead(8'h90);
    check(rd, 32'h1234_5671);
    cfgRead(8'h00);
    check(rd, 32'h0);
    // Power gating on IDE idle and processor sleep, two units of idle time.
    cpuInC3 = 1'b1;
    cfgWrite(8'h98, 4'h1, 32'h0000_00c0);
    cfgWrite(8'h98, 4'h4, 32'h0082_0000);
    gateWait(9, 15);
    check({31'h0, generalPinFiveOe}, 32'h1);
    cpuInC3 = 1'b0;
    tick(2);
    check({31'h0, generalPinFiveOut}, 32'h0);
    cpuInC3 = 1'b1;
    gateWait(9, 15);
    unitIdle = 7'h3e;
    tick(2);
    check({31'h0, generalPinFiveOut}, 32'h0);
    unitIdle = 7'h7e;
    gateWait(9, 15);
    cfgWrite(8'h98, 4'h2, 32'h0000_0100);
    tick(20);
    check({31'h0, generalPinFiveOut}, 32'h0);
    voltageInReached = 8'h01;
    gateWait(9, 18);
    cfgWrite(8'h98, 4'h4, 32'h0);
    tick(3);
    check({generalPinFiveOut, generalPinFiveOe}, 2'h0);
    summarize();
  end
endmodule
`default_nettype wire
